// file: roa_pkg.sv
/*
  roa_pkg: constants, enumerations and carrier structs shared by the
  register-operation datapath.
  Assumes a 16-bit CPU whose decode sequencer feeds operands and stores results.
*/
package roa_pkg;

  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;

  // status register, one word at this offset on the plain register port
  localparam logic [3:0] STATUS_OFFSET = 4'h0;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam int STAT_E_POS = 0;
  localparam int STAT_G_POS = 1;
  localparam int STAT_V_POS = 2;
  localparam int STAT_C_POS = 3;
  localparam int STAT_O_POS = 8;
  localparam int STAT_Z_POS = 9;
  localparam int STAT_N_POS = 10;

  // pointer steps in byte addresses
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_STEP = 16'h0002;

  typedef enum logic [2:0] {
    OP_TRANSFER = 3'h0,
    OP_DIFFERENCE = 3'h1,
    OP_SUM = 3'h2,
    OP_CONJUNCTION = 3'h3,
    OP_INCLUSIVE_DISJUNCTION = 3'h4,
    OP_EXCLUSIVE_DISJUNCTION = 3'h5,
    OP_COMPARISON = 3'h6,
    OP_MASK_CHECK = 3'h7
  } roa_op_t;

  typedef enum logic [1:0] {
    PTR_NONE = 2'h0,
    PTR_INC = 2'h1,
    PTR_DEC = 2'h2
  } roa_ptr_mode_t;

  typedef struct packed {
    roa_op_t op;
    logic byte_sel;
    logic reg_form;
    logic short_imm;
    logic ext;
    logic index_en;
    logic [3:0] imm_k;
    logic [15:0] src;
    logic [15:0] tgt;
    logic [15:0] data_word;
    logic [15:0] index_val;
  } roa_op_req_t;

  typedef struct packed {
    logic [15:0] data;
    logic write;
    logic illegal;
  } roa_op_rsp_t;

  typedef struct packed {
    roa_ptr_mode_t mode;
    logic byte_sel;
    logic [15:0] ptr;
  } roa_ag_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] ptr_next;
  } roa_ag_rsp_t;

  typedef struct packed {
    logic n;
    logic z;
    logic o;
    logic c;
    logic v;
    logic g;
    logic e;
  } roa_flags_t;

endpackage : roa_pkg

// file: roa_datapath.sv
/*
  roa_datapath: two-operand register-operation datapath with status indicators,
  pointer step logic and a plain status register port.
  Assumes the decode sequencer presents one-cycle requests synchronous to clk
  and stores results and pointer updates itself.
*/
// Implementation choices: the register offsets and strobed register access.
// Function
// - code 4 writes source OR target
// - exclusive OR sets differing bits only
// - code 6 compare changes only G and E
// - compare writes nothing; equal/greater/less flag settings
// - code 7 test ANDs, updates only N Z O
// - test writes nothing; Z, N, O from result
// - move copies source, carry/overflow untouched
// - move sets N and Z from source
// - code 1 subtract adds complemented source
// - code 2 add stores sum in target
// - add/subtract carry from most significant bit
// - add/subtract overflow on signed range exit
// - code 3 AND stores bitwise product
// - logic ops set N Z O, keep C V
// - register/data forms are word only, K 0-15
// - auto-increment steps pointer after storing
// - auto-decrement steps pointer before fetching
// - byte-select bit one selects byte mode
// - extension bit picks register or data word
`timescale 1ns/1ps
module roa_datapath (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // operation request and result
  input wire logic op_valid,
  input wire roa_pkg::roa_op_req_t op_req,
  output logic op_done,
  output roa_pkg::roa_op_rsp_t op_result,
  // pointer step request and answer
  input wire logic ag_valid,
  input wire roa_pkg::roa_ag_req_t ag_req,
  output logic ag_done,
  output roa_pkg::roa_ag_rsp_t ag_rsp,
  // status register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] reg_rdata,
  // status indicators
  output roa_pkg::roa_flags_t flags
);

  logic rst_meta_q;
  logic rst_sync_q;
  logic [15:0] src_sel;
  logic [15:0] res_d;
  logic write_d;
  logic illegal_d;
  logic upd_cv;
  logic upd_nzo;
  logic upd_ge;
  roa_pkg::roa_flags_t calc;
  roa_pkg::roa_flags_t flags_q;
  roa_pkg::roa_flags_t flags_d;
  roa_pkg::roa_op_rsp_t result_q;
  logic op_done_q;
  logic ag_done_q;
  roa_pkg::roa_ag_rsp_t ag_rsp_q;
  logic [15:0] rdata_q;

  function automatic logic [2:0] nzo_of(input logic [15:0] r, input logic byte_sel);
    if (byte_sel) begin
      return {r[7], r[7:0] == 8'h00, r[0]};
    end
    return {r[15], r == 16'h0000, r[0]};
  endfunction : nzo_of

  function automatic logic [15:0] pack_status(input roa_pkg::roa_flags_t f);
    logic [15:0] s;
    s = 16'h0000;
    s[roa_pkg::STAT_E_POS] = f.e;
    s[roa_pkg::STAT_G_POS] = f.g;
    s[roa_pkg::STAT_V_POS] = f.v;
    s[roa_pkg::STAT_C_POS] = f.c;
    s[roa_pkg::STAT_O_POS] = f.o;
    s[roa_pkg::STAT_Z_POS] = f.z;
    s[roa_pkg::STAT_N_POS] = f.n;
    return s;
  endfunction : pack_status

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // source selection by form
  always_comb begin
    if (!op_req.reg_form) begin
      src_sel = op_req.src;
    end else if (op_req.short_imm) begin
      src_sel = {12'h000, op_req.imm_k};
    end else if (!op_req.ext) begin
      src_sel = op_req.src;
    end else begin
      src_sel = op_req.data_word + (op_req.index_en ? op_req.index_val : 16'h0000);
    end
  end

  // operation and flag calculation
  always_comb begin
    logic [15:0] s;
    logic [15:0] t;
    logic [15:0] b;
    logic [16:0] sw;
    logic [8:0] sb;
    logic [15:0] r;
    logic cin;
    logic sub;
    logic cout;
    logic ovf;
    cout = 1'b0;
    ovf = 1'b0;
    s = src_sel;
    t = op_req.tgt;
    sub = (op_req.op == roa_pkg::OP_DIFFERENCE) || (op_req.op == roa_pkg::OP_COMPARISON);
    b = sub ? ~s : s;
    cin = sub;
    sw = {1'b0, t} + {1'b0, b} + {16'h0000, cin};
    sb = {1'b0, t[7:0]} + {1'b0, b[7:0]} + {8'h00, cin};
    if (op_req.byte_sel) begin
      cout = sb[8];
      ovf = (t[7] == b[7]) && (sb[7] != t[7]);
    end else begin
      cout = sw[16];
      ovf = (t[15] == b[15]) && (sw[15] != t[15]);
    end
    r = 16'h0000;
    write_d = 1'b0;
    upd_cv = 1'b0;
    upd_nzo = 1'b0;
    upd_ge = 1'b0;
    unique case (op_req.op)
      roa_pkg::OP_TRANSFER: begin
        r = s;
        write_d = 1'b1;
        upd_nzo = 1'b1;
      end
      roa_pkg::OP_DIFFERENCE, roa_pkg::OP_SUM: begin
        r = sw[15:0];
        write_d = 1'b1;
        upd_cv = 1'b1;
        upd_nzo = 1'b1;
      end
      roa_pkg::OP_CONJUNCTION: begin
        r = s & t;
        write_d = 1'b1;
        upd_nzo = 1'b1;
      end
      roa_pkg::OP_INCLUSIVE_DISJUNCTION: begin
        r = s | t;
        write_d = 1'b1;
        upd_nzo = 1'b1;
      end
      roa_pkg::OP_EXCLUSIVE_DISJUNCTION: begin
        r = s ^ t;
        write_d = 1'b1;
        upd_nzo = 1'b1;
      end
      roa_pkg::OP_COMPARISON: begin
        r = t;
        upd_ge = 1'b1;
      end
      roa_pkg::OP_MASK_CHECK: begin
        r = s & t;
        upd_nzo = 1'b1;
      end
    endcase
    calc.c = cout;
    calc.v = ovf;
    {calc.n, calc.z, calc.o} = nzo_of(r, op_req.byte_sel);
    if (op_req.byte_sel) begin
      calc.e = (s[7:0] == t[7:0]);
      calc.g = $signed(s[7:0]) > $signed(t[7:0]);
    end else begin
      calc.e = (s == t);
      calc.g = $signed(s) > $signed(t);
    end
    illegal_d = op_req.byte_sel && op_req.reg_form;
    res_d = op_req.byte_sel ? {t[15:8], r[7:0]} : r;
  end

  // result register
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      op_done_q <= 1'b0;
      result_q <= '0;
    end else begin
      op_done_q <= op_valid;
      if (op_valid) begin
        result_q.data <= res_d;
        result_q.write <= write_d && !illegal_d;
        result_q.illegal <= illegal_d;
      end
    end
  end

  // status indicators: an operation wins over a same-cycle software write
  always_comb begin
    flags_d = flags_q;
    if (reg_we && reg_addr == roa_pkg::STATUS_OFFSET) begin
      flags_d.e = reg_wdata[roa_pkg::STAT_E_POS];
      flags_d.g = reg_wdata[roa_pkg::STAT_G_POS];
      flags_d.v = reg_wdata[roa_pkg::STAT_V_POS];
      flags_d.c = reg_wdata[roa_pkg::STAT_C_POS];
      flags_d.o = reg_wdata[roa_pkg::STAT_O_POS];
      flags_d.z = reg_wdata[roa_pkg::STAT_Z_POS];
      flags_d.n = reg_wdata[roa_pkg::STAT_N_POS];
    end
    if (op_valid && !illegal_d) begin
      if (upd_cv) begin
        flags_d.c = calc.c;
        flags_d.v = calc.v;
      end
      if (upd_nzo) begin
        flags_d.n = calc.n;
        flags_d.z = calc.z;
        flags_d.o = calc.o;
      end
      if (upd_ge) begin
        flags_d.e = calc.e;
        flags_d.g = calc.g;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  // pointer step: decrement before fetch, increment after store
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ag_done_q <= 1'b0;
      ag_rsp_q <= '0;
    end else begin
      ag_done_q <= ag_valid;
      if (ag_valid) begin
        unique case (ag_req.mode)
          roa_pkg::PTR_INC: begin
            ag_rsp_q.addr <= ag_req.ptr;
            ag_rsp_q.ptr_next <= ag_req.ptr + (ag_req.byte_sel ? roa_pkg::BYTE_STEP : roa_pkg::WORD_STEP);
          end
          roa_pkg::PTR_DEC: begin
            ag_rsp_q.addr <= ag_req.ptr - (ag_req.byte_sel ? roa_pkg::BYTE_STEP : roa_pkg::WORD_STEP);
            ag_rsp_q.ptr_next <= ag_req.ptr - (ag_req.byte_sel ? roa_pkg::BYTE_STEP : roa_pkg::WORD_STEP);
          end
          default: begin
            ag_rsp_q.addr <= ag_req.ptr;
            ag_rsp_q.ptr_next <= ag_req.ptr;
          end
        endcase
      end
    end
  end

  // register read, data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_q <= roa_pkg::STATUS_RESET;
    end else if (reg_re) begin
      rdata_q <= (reg_addr == roa_pkg::STATUS_OFFSET) ? pack_status(flags_q) : 16'h0000;
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign op_done = op_done_q;
  assign op_result = result_q;
  assign ag_done = ag_done_q;
  assign ag_rsp = ag_rsp_q;
  assign reg_rdata = rdata_q;
  assign flags = flags_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_q);

  a_or_result: assert property (op_valid && op_req.op == roa_pkg::OP_INCLUSIVE_DISJUNCTION
    && !op_req.byte_sel |=> op_result.write && op_result.data == ($past(src_sel) | $past(op_req.tgt)))
    else $error("inclusive or result wrong");
  a_xor_result: assert property (op_valid && op_req.op == roa_pkg::OP_EXCLUSIVE_DISJUNCTION
    && !op_req.byte_sel |=> op_result.write && op_result.data == ($past(src_sel) ^ $past(op_req.tgt)))
    else $error("exclusive or result wrong");
  a_cmp_flags: assert property (op_valid && op_req.op == roa_pkg::OP_COMPARISON && !op_req.byte_sel
    ##0 !(op_req.reg_form && op_req.byte_sel)
    |=> !op_result.write && flags.e == ($past(src_sel) == $past(op_req.tgt))
        && flags.g == ($signed($past(src_sel)) > $signed($past(op_req.tgt))))
    else $error("compare flags wrong");
  a_cmp_keeps: assert property (op_valid && op_req.op == roa_pkg::OP_COMPARISON && !reg_we
    |=> {flags.c, flags.v, flags.n, flags.z, flags.o} == $past({flags.c, flags.v, flags.n, flags.z, flags.o}))
    else $error("compare touched other flags");
  a_test_flags: assert property (op_valid && op_req.op == roa_pkg::OP_MASK_CHECK && !op_req.byte_sel
    && !reg_we |=> !op_result.write && flags.z == (($past(src_sel) & $past(op_req.tgt)) == 16'h0000)
        && flags.e == $past(flags.e) && flags.c == $past(flags.c))
    else $error("test flags wrong");
  a_move_keeps: assert property (op_valid && op_req.op == roa_pkg::OP_TRANSFER && !op_req.byte_sel
    && !reg_we |=> op_result.data == $past(src_sel) && flags.c == $past(flags.c) && flags.v == $past(flags.v)
        && flags.n == $past(src_sel[15]))
    else $error("move result or flags wrong");
  a_add_carry: assert property (op_valid && op_req.op == roa_pkg::OP_SUM && !op_req.byte_sel
    |=> {flags.c, op_result.data} == ({1'b0, $past(src_sel)} + {1'b0, $past(op_req.tgt)}))
    else $error("sum or carry wrong");
  a_sub_result: assert property (op_valid && op_req.op == roa_pkg::OP_DIFFERENCE && !op_req.byte_sel
    |=> op_result.data == $past(op_req.tgt) - $past(src_sel)
        && flags.v == (($past(op_req.tgt[15]) != $past(src_sel[15]))
        && (op_result.data[15] != $past(op_req.tgt[15]))))
    else $error("difference or overflow wrong");
  a_byte_forbid: assert property (op_valid && op_req.byte_sel && op_req.reg_form
    |=> op_result.illegal && !op_result.write)
    else $error("byte register form not refused");
  a_byte_flags: assert property (op_valid && op_req.byte_sel && !op_req.reg_form
    && op_req.op == roa_pkg::OP_CONJUNCTION
    |=> flags.n == op_result.data[7] && op_result.data[15:8] == $past(op_req.tgt[15:8]))
    else $error("byte result or flag wrong");
  a_step_inc: assert property (ag_valid && ag_req.mode == roa_pkg::PTR_INC && !ag_req.byte_sel
    |=> ag_done && ag_rsp.addr == $past(ag_req.ptr) && ag_rsp.ptr_next == $past(ag_req.ptr) + 16'h0002)
    else $error("auto increment wrong");
  a_step_dec: assert property (ag_valid && ag_req.mode == roa_pkg::PTR_DEC
    |=> ag_done && ag_rsp.addr == ag_rsp.ptr_next && ag_rsp.addr != $past(ag_req.ptr))
    else $error("auto decrement wrong");

  c_compare_equal: cover property (op_valid && op_req.op == roa_pkg::OP_COMPARISON ##1 flags.e);
  c_add_overflow: cover property (op_valid && op_req.op == roa_pkg::OP_SUM ##1 flags.v);
  c_byte_refused: cover property (op_valid && op_req.byte_sel && op_req.reg_form);
  c_back_to_back: cover property (op_valid ##1 op_valid ##1 op_done);

endmodule : roa_datapath

// file: roa_seq_model.sv
/*
  roa_seq_model: stand-in for the decode and operand fetch sequencer.
  Assumes the bench calls its tasks and samples answers one step after the edge.
*/
`timescale 1ns/1ps
module roa_seq_model (
  // clock
  input wire logic clk,
  // operation request
  output logic op_valid,
  output roa_pkg::roa_op_req_t op_req,
  // pointer step request
  output logic ag_valid,
  output roa_pkg::roa_ag_req_t ag_req
);
  initial begin
    op_valid = 1'b0;
    op_req = '0;
    ag_valid = 1'b0;
    ag_req = '0;
  end

  // one operation after an idle gap; fields go to an inverted pattern once taken
  task automatic issue_op(input roa_pkg::roa_op_req_t r, input int gap, input logic bad);
    roa_pkg::roa_op_req_t q;
    q = r;
    if (q.reg_form && !bad) q.byte_sel = 1'b0;
    repeat (gap) @(posedge clk);
    @(posedge clk);
    op_valid <= 1'b1;
    op_req <= q;
    @(posedge clk);
    op_valid <= 1'b0;
    op_req <= ~q;
  endtask : issue_op

  // one pointer step request
  task automatic issue_ag(input roa_pkg::roa_ag_req_t r);
    @(posedge clk);
    ag_valid <= 1'b1;
    ag_req <= r;
    @(posedge clk);
    ag_valid <= 1'b0;
    ag_req <= ~r;
  endtask : issue_ag
endmodule : roa_seq_model

// file: tb_register_op_alu.sv
/*
  tb_register_op_alu: self-checking bench for roa_datapath.
  Assumes roa_pkg and roa_seq_model are compiled first.
*/
`timescale 1ns/1ps
module tb_register_op_alu;
  logic clk;
  logic rst_n;
  logic op_valid;
  roa_pkg::roa_op_req_t op_req;
  logic op_done;
  roa_pkg::roa_op_rsp_t op_result;
  logic ag_valid;
  roa_pkg::roa_ag_req_t ag_req;
  logic ag_done;
  roa_pkg::roa_ag_rsp_t ag_rsp;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_we;
  logic reg_re;
  logic [15:0] reg_rdata;
  roa_pkg::roa_flags_t flags;
  roa_pkg::roa_flags_t ef;
  logic o_known;
  logic [31:0] seed;
  logic [95:0] v;
  logic [15:0] rd;
  roa_pkg::roa_op_req_t r;
  roa_pkg::roa_ag_req_t g;
  logic [15:0] st;
  int failures;
  int checked;

  roa_datapath i_roa_datapath (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_req(op_req),
    .op_done(op_done), .op_result(op_result), .ag_valid(ag_valid), .ag_req(ag_req), .ag_done(ag_done),
    .ag_rsp(ag_rsp), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .flags(flags));
  roa_seq_model i_roa_seq_model (.clk(clk), .op_valid(op_valid), .op_req(op_req), .ag_valid(ag_valid),
    .ag_req(ag_req));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic complete_run();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // expected answer and flag update for one request
  function automatic roa_pkg::roa_op_rsp_t exp_op(input roa_pkg::roa_op_req_t q);
    logic [15:0] m;
    logic [15:0] s;
    logic [15:0] t;
    logic [15:0] x;
    logic [16:0] a;
    logic sub;
    int h;
    roa_pkg::roa_op_rsp_t p;
    p = '0;
    if (q.byte_sel && q.reg_form) begin
      p.illegal = 1'b1;
      return p;
    end
    m = q.byte_sel ? 16'h00FF : 16'hFFFF;
    h = q.byte_sel ? 7 : 15;
    sub = (q.op == roa_pkg::OP_DIFFERENCE);
    s = q.src;
    if (q.reg_form && q.short_imm) s = {12'h000, q.imm_k};
    else if (q.reg_form && q.ext) s = q.data_word + (q.index_en ? q.index_val : 16'h0000);
    s = s & m;
    t = q.tgt & m;
    a = sub ? {1'b0, t} + {1'b0, ~s & m} + 17'h00001 : {1'b0, t} + {1'b0, s};
    case (q.op)
      roa_pkg::OP_TRANSFER: x = s;
      roa_pkg::OP_DIFFERENCE, roa_pkg::OP_SUM: x = a[15:0] & m;
      roa_pkg::OP_CONJUNCTION, roa_pkg::OP_MASK_CHECK: x = s & t;
      roa_pkg::OP_INCLUSIVE_DISJUNCTION: x = s | t;
      roa_pkg::OP_EXCLUSIVE_DISJUNCTION: x = s ^ t;
      default: x = t;
    endcase
    p.write = (q.op != roa_pkg::OP_COMPARISON) && (q.op != roa_pkg::OP_MASK_CHECK);
    p.data = (q.tgt & ~m) | x;
    if (q.op == roa_pkg::OP_COMPARISON) begin
      ef.e = (s == t);
      ef.g = q.byte_sel ? ($signed(s[7:0]) > $signed(t[7:0])) : ($signed(s) > $signed(t));
    end else begin
      ef.n = x[h];
      ef.z = (x == 16'h0000);
      o_known = (q.op != roa_pkg::OP_TRANSFER);
      ef.o = x[0];
      if (sub || q.op == roa_pkg::OP_SUM) begin
        ef.c = q.byte_sel ? a[8] : a[16];
        ef.v = ((s[h] ^ sub) == t[h]) && (x[h] != t[h]);
      end
    end
    return p;
  endfunction : exp_op

  task automatic run_op(input roa_pkg::roa_op_req_t q, input int gap, input logic bad);
    roa_pkg::roa_op_rsp_t e;
    logic [6:0] fm;
    e = exp_op(q);
    fm = o_known ? 7'h7F : 7'h6F;
    i_roa_seq_model.issue_op(q, gap, bad);
    #1;
    chk("op_done", op_done, 1'b1);
    chk("illegal", op_result.illegal, e.illegal);
    chk("write", op_result.write, e.write);
    if (e.write) chk("data", op_result.data, e.data);
    chk("flags", flags & fm, ef & fm);
  endtask : run_op

  function automatic roa_pkg::roa_op_req_t mk(input roa_pkg::roa_op_t o, input logic b, input logic [31:0] st_);
    roa_pkg::roa_op_req_t q;
    q = '0;
    q.op = o;
    q.byte_sel = b;
    q.src = st_[31:16];
    q.tgt = st_[15:0];
    return q;
  endfunction : mk

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_rd

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_we = 1'b0;
    reg_re = 1'b0;
    seed = 32'd54651;
    failures = 0;
    checked = 0;
    ef = '0;
    o_known = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // status register reset value, access, unmapped places
    reg_rd(roa_pkg::STATUS_OFFSET, rd);
    chk("status_reset", rd, roa_pkg::STATUS_RESET);
    reg_wr(roa_pkg::STATUS_OFFSET, 16'hFFFF);
    reg_wr(4'h1, 16'h0000);
    reg_rd(roa_pkg::STATUS_OFFSET, rd);
    chk("status_rw", rd, 16'h070F);
    reg_rd(4'h5, rd);
    chk("unmapped", rd, 16'h0000);
    ef = 7'h7F;
    $display("test status done");
    // corner cases
    run_op(mk(roa_pkg::OP_SUM, 1'b0, 32'h0001_7FFF), 0, 1'b0);
    run_op(mk(roa_pkg::OP_SUM, 1'b0, 32'h0001_FFFF), 0, 1'b0);
    run_op(mk(roa_pkg::OP_DIFFERENCE, 1'b0, 32'h0001_8000), 0, 1'b0);
    run_op(mk(roa_pkg::OP_DIFFERENCE, 1'b0, 32'h0005_0005), 1, 1'b0);
    run_op(mk(roa_pkg::OP_SUM, 1'b1, 32'h007F_AB01), 0, 1'b0);
    run_op(mk(roa_pkg::OP_DIFFERENCE, 1'b1, 32'h0001_1200), 0, 1'b0);
    run_op(mk(roa_pkg::OP_COMPARISON, 1'b0, 32'h1234_1234), 0, 1'b0);
    run_op(mk(roa_pkg::OP_COMPARISON, 1'b0, 32'h0005_0003), 0, 1'b0);
    run_op(mk(roa_pkg::OP_COMPARISON, 1'b0, 32'h8000_0003), 0, 1'b0);
    run_op(mk(roa_pkg::OP_COMPARISON, 1'b1, 32'h1105_2205), 0, 1'b0);
    run_op(mk(roa_pkg::OP_MASK_CHECK, 1'b0, 32'h00F0_FF0F), 0, 1'b0);
    run_op(mk(roa_pkg::OP_MASK_CHECK, 1'b0, 32'h8001_8001), 0, 1'b0);
    run_op(mk(roa_pkg::OP_TRANSFER, 1'b0, 32'h8000_1234), 0, 1'b0);
    run_op(mk(roa_pkg::OP_TRANSFER, 1'b0, 32'h0000_FFFF), 0, 1'b0);
    r = mk(roa_pkg::OP_SUM, 1'b0, 32'h0000_0010);
    r.reg_form = 1'b1;
    r.short_imm = 1'b1;
    r.imm_k = 4'hF;
    run_op(r, 0, 1'b0);
    r.short_imm = 1'b0;
    r.ext = 1'b1;
    r.index_en = 1'b1;
    r.data_word = 16'h0100;
    r.index_val = 16'h0020;
    run_op(r, 0, 1'b0);
    r.byte_sel = 1'b1;
    run_op(r, 0, 1'b1);
    $display("test corners done");
    // random traffic
    repeat (300) begin
      v = {rnd(), rnd(), rnd()};
      r = v[75:0];
      if (r.reg_form) r.byte_sel = 1'b0;
      if (r.short_imm) r.ext = 1'b0;
      run_op(r, int'(v[95:94]), 1'b0);
    end
    $display("test random done");
    // pointer steps in every mode and size
    for (int i = 0; i < 6; i++) begin
      v = {rnd(), rnd(), rnd()};
      g.mode = roa_pkg::roa_ptr_mode_t'(i % 3);
      g.byte_sel = i[0];
      g.ptr = v[15:0];
      st = g.byte_sel ? roa_pkg::BYTE_STEP : roa_pkg::WORD_STEP;
      i_roa_seq_model.issue_ag(g);
      #1;
      chk("ag_done", ag_done, 1'b1);
      chk("ag_addr", ag_rsp.addr, (g.mode == roa_pkg::PTR_DEC) ? g.ptr - st : g.ptr);
      chk("ag_next", ag_rsp.ptr_next, (g.mode == roa_pkg::PTR_NONE) ? g.ptr :
        (g.mode == roa_pkg::PTR_INC) ? g.ptr + st : g.ptr - st);
    end
    $display("test pointer done");
    complete_run();
  end
endmodule : tb_register_op_alu
